// ### dv/skio_pmem_model.sv
// Program memory model that feeds instruction bytes to the execution unit
`timescale 1ns/1ps
module skio_pmem_model (
  // Fetch port
  input  wire logic [10:0] pm_addr,
  output logic      [7:0]  pm_data
);
  logic [7:0] rom [0:2047];

  // Blank locations hold a byte that no form decodes, so stray fetches do nothing
  initial begin
    for (int i = 0; i < 2048; i++) rom[i] = 8'h00;
  end

  // Same-clock memory: data follows the address with no wait
  assign pm_data = rom[pm_addr];

  task automatic load(input logic [10:0] a, input logic [7:0] b);
    rom[a] = b;
  endtask
endmodule

// ### dv/tb_skip_interrupt_idle_ops.sv
// Self-checking bench for the skip/idle execution unit
`timescale 1ns/1ps
module tb_skip_interrupt_idle_ops;
  localparam int K_NOP = 0, K_CRI = 1, K_CHI = 2, K_CAR = 3, K_CAH = 4, K_CEH = 5, K_CER = 6;
  localparam int K_DR = 7, K_DRR = 8, K_IR = 9, K_IRR = 10, K_IM = 11, K_IE = 12;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, mie, idle, er;
  logic [7:0]  paddr, pm_data;
  logic [10:0] pm_addr;
  logic [31:0] pwdata, prdata, rd;
  int          failures, cmp_count, cyc, m_pc, m_ticks, m_skip, m_ie, m_c, pc_idle, t0;
  int          seed = 32'h92e5;
  int          m_rg[8];
  int          m_mem[256];

  skio_core skio_core_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data),
    .master_interrupt_enable(mie), .cpu_idle(idle));
  skio_pmem_model skio_pmem_model_i (.pm_addr(pm_addr), .pm_data(pm_data));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // ==========================================================
  // Bus and check helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic memwr(input int a, input int d);
    apb(1'b1, 8'h14, a);
    apb(1'b1, 8'h18, d);
    m_mem[a] = d;
  endtask

  task automatic memchk(input int a);
    apb(1'b1, 8'h14, a);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd[3:0], m_mem[a], "data memory");
  endtask

  // ==========================================================
  // Reference model, advanced as each instruction is emitted
  function automatic int pv(input int p);
    return m_rg[2 * p] + 16 * m_rg[2 * p + 1];
  endfunction

  task automatic op(input logic [7:0] b0, input int k, input logic [7:0] b1 = 8'h00,
                    input int x = 0, input int y = 0);
    int len, hl, v, ex;
    len = (b0 inside {8'hd9, 8'hdd, 8'hdc, 8'hca, 8'hfe, 8'hff}) ? 2 : 1;
    ex = !m_skip;
    hl = pv(1);
    skio_pmem_model_i.load(m_pc[10:0], b0);
    if (len == 2) skio_pmem_model_i.load(m_pc[10:0] + 11'h1, b1);
    m_pc += len;
    // A skipped instruction still costs its fetch cycles
    m_ticks += len;
    m_skip = 0;
    if (ex) case (k)
      K_CRI: m_skip = m_rg[x] == y;
      K_CHI: m_skip = m_mem[hl] == y;
      K_CAR: m_skip = m_rg[0] == m_rg[x];
      K_CAH: m_skip = m_rg[0] == m_mem[hl];
      K_CEH: m_skip = m_rg[0] == m_mem[hl] && m_rg[1] == m_mem[(hl + 1) % 256];
      K_CER: m_skip = pv(0) == pv(x);
      K_DR: begin
        m_skip = m_rg[x] == 0;
        m_rg[x] = (m_rg[x] + 15) % 16;
      end
      K_DRR, K_IRR: begin
        v = (k == K_DRR) ? (pv(x) + 255) % 256 : (pv(x) + 1) % 256;
        m_skip = (k == K_DRR) ? v == 255 : v == 0;
        m_rg[2 * x] = v % 16;
        m_rg[2 * x + 1] = v / 16;
      end
      K_IR: begin
        m_rg[x] = (m_rg[x] + 1) % 16;
        m_skip = m_rg[x] == 0;
      end
      K_IM: begin
        m_mem[x] = (m_mem[x] + 1) % 16;
        m_skip = m_mem[x] == 0;
      end
      K_IE: m_ie = x;
      default: m_skip = 0;
    endcase
  endtask

  // Immediates are taken from the model so the first compares always hit or miss
  task automatic prog();
    int hl;
    hl = pv(1);
    op(8'hd9, K_CRI, {m_rg[4][3:0], 4'h4}, 4, m_rg[4]);
    op(8'h5d, K_IR, 8'h00, 5);
    op(8'hd9, K_CRI, {m_rg[5][3:0] ^ 4'h1, 4'h5}, 5, m_rg[5] ^ 1);
    op(8'hdd, K_CHI, {4'h7, m_mem[hl][3:0]}, 0, m_mem[hl]);
    op(8'hfe, K_IE, 8'hb2, 0);
    op(8'hff, K_IE, 8'hb2, 1);
    op(8'hdd, K_CAR, 8'h6e, 6);
    op(8'h00, K_NOP);
    op(8'h38, K_CAH);
    op(8'h00, K_NOP);
    op(8'hdc, K_CEH, 8'h09);
    op(8'h00, K_NOP);
    op(8'hdc, K_CER, 8'hee, 3);
    op(8'h00, K_NOP);
    op(8'h84, K_IRR, 8'h00, 2);
    op(8'h00, K_NOP);
    op(8'h4c, K_DR, 8'h00, 4);
    op(8'h00, K_NOP);
    op(8'hdc, K_DRR, 8'hde, 3);
    op(8'h00, K_NOP);
    op(8'h5e, K_IR, 8'h00, 6);
    op(8'h00, K_NOP);
    op(8'hca, K_IM, 8'h20, 32);
    op(8'hfe, K_IE, 8'hb2, 0);
    op(8'hdd, K_IM, 8'h62, hl);
    op(8'h00, K_NOP);
    op(8'hff, K_NOP, 8'ha3);
    pc_idle = m_pc;
    repeat (3) op(8'h00, K_NOP);
  endtask

  // ==========================================================
  // One program run from register setup to idle and readback
  task automatic run(input logic [31:0] rv, input int d0, input int d1, input int d2,
                     input int c, input int dv);
    int          hl, exp_cyc;
    logic [31:0] tk, ex;
    for (int i = 0; i < 8; i++) m_rg[i] = rv[4 * i +: 4];
    hl = pv(1);
    apb(1'b1, 8'h10, rv);
    memwr(hl, d0);
    memwr((hl + 1) % 256, d1);
    memwr(32, d2);
    apb(1'b1, 8'h1c, c);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    m_c = c;
    m_ie = 0;
    m_pc = 0;
    m_ticks = 0;
    m_skip = 0;
    prog();
    apb(1'b1, 8'h00, 32'h1 | (dv << 1));
    t0 = cyc;
    while (pm_addr === 11'h0 && cyc - t0 < 200) @(posedge mclk);
    t0 = cyc;
    while (idle !== 1'b1 && cyc - t0 < 4000) @(posedge mclk);
    // Span from first to idle tick; the three padding no-ops are never fetched
    exp_cyc = ((dv == 2) ? 64 : (dv == 1) ? 8 : 4) * (m_ticks - 4);
    chk(cyc - t0, exp_cyc, "cycles");
    repeat (20) @(posedge mclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[10:0], pc_idle, "pc");
    apb(1'b0, 8'h20, 32'h0);
    tk = rd;
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rd !== tk}, 32'h1, "time base");
    for (int i = 0; i < 8; i++) ex[4 * i +: 4] = m_rg[i][3:0];
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, ex, "regs");
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd[0], m_c, "carry");
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[3], mie}, {2{m_ie[0]}}, "enable");
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[2], idle}, 2'b11, "idle");
    memchk(hl);
    memchk((hl + 1) % 256);
    memchk(32);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({pm_addr, mie, idle}, 32'h0, "reset outputs");
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset and bus done");
    run($random(seed), $random(seed) & 15, $random(seed) & 15, $random(seed) & 15, 1, 0);
    $display("test random operands done");
    run(32'h00ff0000, 0, 0, 15, 0, 2);
    $display("test forced skips done");
    run($random(seed), $random(seed) & 15, $random(seed) & 15, 15, $random(seed) & 1, 1);
    $display("test divided clock done");
    results();
  end

  // Three runs take about three and a half thousand cycles, the slowest divider dominating
  initial begin
    repeat (20000) @(posedge mclk);
    $display("[FAIL] %0t watchdog expired", $time);
    failures++;
    results();
  end
endmodule

// ### verilog/skio_core.sv
// Execution unit for compare/decrement/increment-skip, interrupt enable and idle
//
// Overview of operation
// [RULE1] compare_skip_equal skips when destination minus source is zero and writes neither.
// [RULE2] Accumulator-versus-indirect compare is one byte, 1+S; other compares two, 2+S.
// [RULE3] The extended_accumulator compare with memory checks A at the pointer and E at pointer+1.
// [RULE4] A compare of extended_accumulator against a selected_register_pair skips on equality.
// [RULE5] decrement_skip_borrow subtracts one from its target and skips when a borrow results.
// [RULE6] A register pair at zero wraps to all ones and counts as a borrow.
// [RULE7] Register decrement-skip is one byte, 1+S cycles; pair form two bytes, 2+S cycles.
// [RULE8] Neither decrement nor increment skip touches the carry flag.
// [RULE9] interrupts_off_instr clears master_interrupt_enable, bit 3 of interrupt_priority_reg.
// [RULE10] interrupts_on_instr sets master_interrupt_enable so latched sources get served.
// [RULE11] The idle instruction sets bit 2 of power_control_reg, halting the CPU clock only.
// [RULE12] Peripheral logic keeps running on the system clock during idle.
// [RULE13] The idle instruction is two bytes and two machine cycles.
// [RULE14] Software should follow the idle instruction with at least three no-operations.
// [RULE15] increment_skip_carry adds one, wrapping all ones to zero, and skips on carry out.
// [RULE16] Register and pair increment-skip: one byte, 1+S; memory forms: two bytes, 2+S.
// [RULE17] A met skip condition fetches and discards the next instruction, costing S cycles.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "skio_map.svh"
module skio_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory, same clock, data follows pm_addr
  output logic      [10:0] pm_addr,
  input  wire logic [7:0]  pm_data,
  // Status to the rest of the chip
  output logic             master_interrupt_enable,
  output logic             cpu_idle
);
  skio_pkg::skio_core_t s_reg;
  skio_pkg::skio_core_t s_next;
  logic [3:0]           dmem [256];
  logic                 mem_we;
  logic [7:0]           mem_wa;
  logic [3:0]           mem_wd;
  logic                 skip;
  logic                 cmp_op;
  logic                 exec;
  logic [7:0]           hl;
  logic [7:0]           da;
  logic [4:0]           sum5;
  logic [8:0]           sum9;
  logic                 apb_wr;
  skio_tick_if          tk ();

  skio_tick u_tick (
    .mclk (mclk),
    .rst  (rst),
    .tk   (tk.gen)
  );

  // ==========================================================
  // Decoding helpers
  function automatic logic two_byte(input logic [7:0] b);
    two_byte = (b == `SKIO_OP_COMPARE_SKIP_EQUAL_RIM) || (b == `SKIO_OP_GRP_DD) ||
               (b == `SKIO_OP_GRP_DC) || (b == `SKIO_OP_INCREMENT_SKIP_CARRY_DA) ||
               (b == `SKIO_OP_GRP_FE) || (b == `SKIO_OP_GRP_FF);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SKIO_ADDR_CTRL) || (a == `SKIO_ADDR_PC) || (a == `SKIO_ADDR_IPR) ||
             (a == `SKIO_ADDR_POWER_CONTROL_REG) || (a == `SKIO_ADDR_REGS) || (a == `SKIO_ADDR_MADDR) ||
             (a == `SKIO_ADDR_MDATA) || (a == `SKIO_ADDR_FLAGS) || (a == `SKIO_ADDR_TICKS);
  endfunction

  assign hl     = {s_reg.regs[`SKIO_REG_H], s_reg.regs[`SKIO_REG_L]};
  assign apb_wr = psel && penable && s_reg.pready && pwrite;

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_wa = hl;
    mem_wd = 4'h0;
    skip   = 1'b0;
    cmp_op = 1'b0;
    exec   = 1'b0;
    da     = pm_data;
    sum5   = 5'h00;
    sum9   = 9'h000;
    if (tk.cpu_tick) begin
      s_next.pc = s_reg.pc + 11'h001;
      unique case (s_reg.st)
        skio_pkg::ST_FETCH1: begin
          if (two_byte(pm_data)) begin
            s_next.op0 = pm_data;
            s_next.st  = skio_pkg::ST_FETCH2;
          end else begin
            exec = 1'b1;
            if (pm_data == `SKIO_OP_COMPARE_SKIP_EQUAL_A_HL) begin
              cmp_op = 1'b1;
              skip   = s_reg.regs[`SKIO_REG_A] == dmem[hl];  // see [RULE2]
            end else if (pm_data[7:3] == `SKIO_OP_DECREMENT_SKIP_BORROW_R) begin
              sum5 = {1'b0, s_reg.regs[pm_data[2:0]]} - 5'h01;
              s_next.regs[pm_data[2:0]] = sum5[3:0];
              skip = sum5[4];  // see [RULE5] see [RULE7]
            end else if (pm_data[7:3] == `SKIO_OP_INCREMENT_SKIP_CARRY_R) begin
              sum5 = {1'b0, s_reg.regs[pm_data[2:0]]} + 5'h01;
              s_next.regs[pm_data[2:0]] = sum5[3:0];
              skip = sum5[4];  // see [RULE15] see [RULE16]
            end else if (pm_data[7:3] == `SKIO_OP_INCREMENT_SKIP_CARRY_RRB && !pm_data[0]) begin
              sum9 = {1'b0, s_reg.regs[{pm_data[2:1], 1'b1}],
                      s_reg.regs[{pm_data[2:1], 1'b0}]} + 9'h001;
              s_next.regs[{pm_data[2:1], 1'b1}] = sum9[7:4];
              s_next.regs[{pm_data[2:1], 1'b0}] = sum9[3:0];
              skip = sum9[8];  // see [RULE15] see [RULE16]
            end
          end
        end
        skio_pkg::ST_FETCH2: begin
          exec = 1'b1;
          unique case (s_reg.op0)
            `SKIO_OP_COMPARE_SKIP_EQUAL_RIM: begin
              cmp_op = 1'b1;
              skip   = !pm_data[3] && (s_reg.regs[pm_data[2:0]] == pm_data[7:4]);  // see [RULE1]
            end
            `SKIO_OP_GRP_DD: begin
              if (pm_data[7:4] == `SKIO_B1_HL_IM) begin
                cmp_op = 1'b1;
                skip   = dmem[hl] == pm_data[3:0];  // see [RULE1]
              end else if (pm_data[7:3] == `SKIO_B1_A_R) begin
                cmp_op = 1'b1;
                skip   = s_reg.regs[`SKIO_REG_A] == s_reg.regs[pm_data[2:0]];
              end else if (pm_data == `SKIO_B1_INCREMENT_SKIP_CARRY_HL) begin
                sum5   = {1'b0, dmem[hl]} + 5'h01;
                mem_we = 1'b1;
                mem_wd = sum5[3:0];
                skip   = sum5[4];  // see [RULE15]
              end
            end
            `SKIO_OP_GRP_DC: begin
              if (pm_data == `SKIO_B1_EA_HL) begin
                cmp_op = 1'b1;
                skip   = (s_reg.regs[`SKIO_REG_A] == dmem[hl]) &&
                         (s_reg.regs[`SKIO_REG_E] == dmem[hl + 8'h01]);  // see [RULE3]
              end else if (pm_data[7:3] == `SKIO_B1_EA_RR && !pm_data[0]) begin
                cmp_op = 1'b1;
                skip   = {s_reg.regs[`SKIO_REG_E], s_reg.regs[`SKIO_REG_A]} ==
                         {s_reg.regs[{pm_data[2:1], 1'b1}],
                          s_reg.regs[{pm_data[2:1], 1'b0}]};  // see [RULE4]
              end else if (pm_data[7:3] == `SKIO_B1_DECREMENT_SKIP_BORROW_RR && !pm_data[0]) begin
                sum9 = {1'b0, s_reg.regs[{pm_data[2:1], 1'b1}],
                        s_reg.regs[{pm_data[2:1], 1'b0}]} - 9'h001;
                s_next.regs[{pm_data[2:1], 1'b1}] = sum9[7:4];
                s_next.regs[{pm_data[2:1], 1'b0}] = sum9[3:0];
                skip = sum9[8];  // see [RULE6] see [RULE7]
              end
            end
            `SKIO_OP_INCREMENT_SKIP_CARRY_DA: begin
              da     = pm_data;
              sum5   = {1'b0, dmem[da]} + 5'h01;
              mem_we = 1'b1;
              mem_wa = da;
              mem_wd = sum5[3:0];
              skip   = sum5[4];  // see [RULE15] see [RULE16]
            end
            `SKIO_OP_GRP_FE: begin
              if (pm_data == `SKIO_B1_INTEN) begin
                s_next.interrupt_priority_reg[`SKIO_IME_BIT] = 1'b0;  // see [RULE9]
              end
            end
            `SKIO_OP_GRP_FF: begin
              if (pm_data == `SKIO_B1_INTEN) begin
                s_next.interrupt_priority_reg[`SKIO_IME_BIT] = 1'b1;  // see [RULE10]
              end else if (pm_data == `SKIO_B1_IDLE) begin
                s_next.power_control_reg[`SKIO_IDLE_BIT] = 1'b1;  // see [RULE11] see [RULE13]
              end
            end
            default: begin
              exec = 1'b1;
            end
          endcase
        end
        skio_pkg::ST_SKIP1: begin
          // Discarded bytes are fetched but never decoded beyond length
          s_next.st = two_byte(pm_data) ? skio_pkg::ST_SKIP2 : skio_pkg::ST_FETCH1; // see [RULE17]
        end
        skio_pkg::ST_SKIP2: begin
          s_next.st = skio_pkg::ST_FETCH1;  // see [RULE17]
        end
      endcase
      if (exec) begin
        s_next.last_skip = skip;
        s_next.st = skip ? skio_pkg::ST_SKIP1 : skio_pkg::ST_FETCH1;  // see [RULE17]
      end
    end

    // APB: answer one cycle into the access phase, commit at that edge
    s_next.pready  = psel && penable && !s_reg.pready;
    s_next.pslverr = psel && penable && !s_reg.pready && !mapped(paddr);
    if (psel && penable && !s_reg.pready) begin
      unique case (paddr)
        `SKIO_ADDR_CTRL:  s_next.prdata = {29'h0, s_reg.div_sel, s_reg.run};
        `SKIO_ADDR_PC:    s_next.prdata = {21'h0, s_reg.pc};
        `SKIO_ADDR_IPR:   s_next.prdata = {28'h0, s_reg.interrupt_priority_reg};
        `SKIO_ADDR_POWER_CONTROL_REG:  s_next.prdata = {28'h0, s_reg.power_control_reg};
        `SKIO_ADDR_REGS:  s_next.prdata = s_reg.regs;
        `SKIO_ADDR_MADDR: s_next.prdata = {24'h0, s_reg.mem_addr};
        `SKIO_ADDR_MDATA: s_next.prdata = {28'h0, dmem[s_reg.mem_addr]};
        `SKIO_ADDR_FLAGS: s_next.prdata = {30'h0, s_reg.last_skip, s_reg.carry};
        `SKIO_ADDR_TICKS: s_next.prdata = {16'h0, tk.periph_count};  // see [RULE12]
        default:          s_next.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        `SKIO_ADDR_CTRL: begin
          s_next.run     = pwdata[`SKIO_CTRL_RUN];
          s_next.div_sel = pwdata[`SKIO_CTRL_DIV_LO +: 2];
        end
        `SKIO_ADDR_PC:    s_next.pc = pwdata[10:0];
        `SKIO_ADDR_IPR:   s_next.interrupt_priority_reg = pwdata[3:0];
        // Clearing the idle bit is the only wake-up path here
        `SKIO_ADDR_POWER_CONTROL_REG:  s_next.power_control_reg = pwdata[3:0];
        `SKIO_ADDR_REGS:  s_next.regs = pwdata;
        `SKIO_ADDR_MADDR: s_next.mem_addr = pwdata[7:0];
        `SKIO_ADDR_FLAGS: s_next.carry = pwdata[`SKIO_FLAG_CARRY];  // see [RULE8]
        default: begin
          s_next.run = s_reg.run;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.st      <= skio_pkg::ST_FETCH1;
      s_reg.pc      <= `SKIO_PC_RST;
      s_reg.div_sel <= `SKIO_DIV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus write wins over the core in the same cycle
  always_ff @(posedge mclk) begin
    if (apb_wr && paddr == `SKIO_ADDR_MDATA) begin
      dmem[s_reg.mem_addr] <= pwdata[3:0];
    end else if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  assign tk.div_sel = s_reg.div_sel;
  assign tk.halt    = !s_reg.run || s_reg.power_control_reg[`SKIO_IDLE_BIT];  // see [RULE11]

  assign prdata                  = s_reg.prdata;
  assign pready                  = s_reg.pready;
  assign pslverr                 = s_reg.pslverr;
  assign pm_addr                 = s_reg.pc;
  assign master_interrupt_enable = s_reg.interrupt_priority_reg[`SKIO_IME_BIT];
  assign cpu_idle                = s_reg.power_control_reg[`SKIO_IDLE_BIT];

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_carry_kept: assert property (!(apb_wr && paddr == `SKIO_ADDR_FLAGS) |=> // see [RULE8]
    s_reg.carry == $past(s_reg.carry)) else $error("carry changed by execution");
  a_di_clears: assert property (tk.cpu_tick && s_reg.st == skio_pkg::ST_FETCH2 && // see [RULE9]
    s_reg.op0 == `SKIO_OP_GRP_FE && pm_data == `SKIO_B1_INTEN && !apb_wr
    |=> !master_interrupt_enable)
    else $error("disable did not clear enable");
  a_ei_sets: assert property (tk.cpu_tick && s_reg.st == skio_pkg::ST_FETCH2 && // see [RULE10]
    s_reg.op0 == `SKIO_OP_GRP_FF && pm_data == `SKIO_B1_INTEN && !apb_wr
    |=> master_interrupt_enable)
    else $error("enable did not set enable");
  a_idle_halts: assert property (cpu_idle |=> !tk.cpu_tick) // see [RULE11]
    else $error("cpu tick while idle");
  a_periph_runs: assert property (cpu_idle |=> // see [RULE12]
    tk.periph_count != $past(tk.periph_count))
    else $error("peripheral base stopped in idle");
  a_skip_enters: assert property (exec && skip && !apb_wr |=> // see [RULE17]
    s_reg.st == skio_pkg::ST_SKIP1)
    else $error("skip not taken");
  a_cmp_keeps: assert property (exec && cmp_op && !apb_wr |=> // see [RULE1]
    s_reg.regs == $past(s_reg.regs))
    else $error("compare modified a register");
  a_two_byte_len: assert property (tk.cpu_tick && // see [RULE13]
    s_reg.st == skio_pkg::ST_FETCH1 && two_byte(pm_data) && !apb_wr |=>
    s_reg.st == skio_pkg::ST_FETCH2 && !tk.cpu_tick)
    else $error("two-byte form not fetched twice");
  a_one_byte_len: assert property (tk.cpu_tick && // see [RULE2]
    s_reg.st == skio_pkg::ST_FETCH1 && !two_byte(pm_data) && !skip && !apb_wr |=>
    s_reg.st == skio_pkg::ST_FETCH1)
    else $error("one-byte form took extra cycle");
endmodule

// ### verilog/skio_map.svh
// Address map, field positions, opcodes and timing counts of the skip/idle execution unit
`ifndef SKIO_MAP_SVH
`define SKIO_MAP_SVH
// ==========================================================
// Register byte addresses
`define SKIO_ADDR_CTRL   8'h00
`define SKIO_ADDR_PC     8'h04
`define SKIO_ADDR_IPR    8'h08
`define SKIO_ADDR_POWER_CONTROL_REG   8'h0c
`define SKIO_ADDR_REGS   8'h10
`define SKIO_ADDR_MADDR  8'h14
`define SKIO_ADDR_MDATA  8'h18
`define SKIO_ADDR_FLAGS  8'h1c
`define SKIO_ADDR_TICKS  8'h20
// ==========================================================
// Fields and reset values
`define SKIO_CTRL_RUN    0
`define SKIO_CTRL_DIV_LO 1
`define SKIO_IME_BIT     3
`define SKIO_IDLE_BIT    2
`define SKIO_FLAG_CARRY  0
`define SKIO_FLAG_SKIP   1
`define SKIO_PC_RST      11'h000
`define SKIO_DIV_RST     2'h0
// ==========================================================
// Register indices: A E L H, pair 0 is the extended accumulator
`define SKIO_REG_A       3'h0
`define SKIO_REG_E       3'h1
`define SKIO_REG_L       3'h2
`define SKIO_REG_H       3'h3
// ==========================================================
// First bytes and second-byte patterns
`define SKIO_OP_COMPARE_SKIP_EQUAL_A_HL 8'h38
`define SKIO_OP_DECREMENT_SKIP_BORROW_R    5'b01001
`define SKIO_OP_INCREMENT_SKIP_CARRY_R    5'b01011
`define SKIO_OP_INCREMENT_SKIP_CARRY_RRB  5'b10000
`define SKIO_OP_COMPARE_SKIP_EQUAL_RIM  8'hd9
`define SKIO_OP_GRP_DD    8'hdd
`define SKIO_OP_GRP_DC    8'hdc
`define SKIO_OP_INCREMENT_SKIP_CARRY_DA   8'hca
`define SKIO_OP_GRP_FE    8'hfe
`define SKIO_OP_GRP_FF    8'hff
`define SKIO_B1_HL_IM     4'h7
`define SKIO_B1_A_R       5'b01101
`define SKIO_B1_INCREMENT_SKIP_CARRY_HL   8'h62
`define SKIO_B1_EA_HL     8'h09
`define SKIO_B1_EA_RR     5'b11101
`define SKIO_B1_DECREMENT_SKIP_BORROW_RR   5'b11011
`define SKIO_B1_INTEN     8'hb2
`define SKIO_B1_IDLE      8'ha3
// ==========================================================
// CPU clock divider: last count value, one less than system cycles per machine cycle
`define SKIO_DIV_4       6'd3
`define SKIO_DIV_8       6'd7
`define SKIO_DIV_64      6'd63
`endif

// ### verilog/skio_pkg.sv
// Types shared by the skip/idle execution unit
package skio_pkg;
  typedef enum logic [3:0] {
    ST_FETCH1 = 4'b0001,
    ST_FETCH2 = 4'b0010,
    ST_SKIP1  = 4'b0100,
    ST_SKIP2  = 4'b1000
  } skio_state_t;

  typedef struct packed {
    skio_state_t           st;
    logic [10:0]           pc;
    logic [7:0]            op0;
    logic [7:0][3:0]       regs;
    logic                  carry;
    logic [3:0]            interrupt_priority_reg;
    logic [3:0]            power_control_reg;
    logic                  run;
    logic [1:0]            div_sel;
    logic [7:0]            mem_addr;
    logic                  last_skip;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } skio_core_t;

  typedef struct packed {
    logic [5:0]            cnt;
    logic                  tick;
    logic [15:0]           periph;
  } skio_tick_state_t;
endpackage

// ### verilog/skio_tick.sv
// Machine-cycle enable divider and free-running peripheral time base
`timescale 1ns/1ps
`include "skio_map.svh"
module skio_tick (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core link
  skio_tick_if.gen tk
);
  skio_pkg::skio_tick_state_t s_reg;
  skio_pkg::skio_tick_state_t s_next;
  logic [5:0]                 limit;

  always_comb begin
    s_next = s_reg;
    unique case (tk.div_sel)
      2'h1:    limit = `SKIO_DIV_8;
      2'h2:    limit = `SKIO_DIV_64;
      default: limit = `SKIO_DIV_4;
    endcase
    // Peripheral base never stops: only the CPU enable is gated in idle
    s_next.periph = s_reg.periph + 16'h0001;
    if (s_reg.cnt >= limit) begin
      s_next.cnt = 6'h00;
    end else begin
      s_next.cnt = s_reg.cnt + 6'h01;
    end
    s_next.tick = (s_reg.cnt >= limit) && !tk.halt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tk.cpu_tick     = s_reg.tick;
  assign tk.periph_count = s_reg.periph;
endmodule

// ### verilog/skio_tick_if.sv
// Link between the execution core and its machine-cycle divider
`timescale 1ns/1ps
interface skio_tick_if;
  logic [1:0]  div_sel;
  logic        halt;
  logic        cpu_tick;
  logic [15:0] periph_count;
  modport core (output div_sel, output halt, input cpu_tick, input periph_count);
  modport gen  (input div_sel, input halt, output cpu_tick, output periph_count);
endinterface
